// >>> logic/umsi_top.sv
// modem and control signal interface of an async communications element
// assumes modem pins are asynchronous; receiver logic outside supplies its own status events
`timescale 1ns/1ns
module umsi_top (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic master_reset_in,

	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,

	input wire logic [7:0] data_bus_in,
	output logic [7:0] data_bus_out,
	output logic data_bus_oe,
	output logic driver_disable,

	input wire umsi_pkg::umsi_modem_t modem_in,
	output logic terminal_ready_n,
	output logic send_request_n,
	output logic user_output_a,
	output logic user_output_b,
	output logic interrupt_request_out,

	input wire logic receive_baud_clock_in,
	output logic rx_sample_tick,
	input wire logic rx_error_evt,
	input wire logic rx_data_avail,
	input wire logic rx_timeout_evt,
	input wire logic fifo_mode,
	input wire logic tx_holding_empty
);
	umsi_pkg::umsi_modem_t sync1_r;
	umsi_pkg::umsi_modem_t sync2_r;
	umsi_pkg::umsi_modem_t prev_r;
	logic [3:0] flags_r;
	logic [3:0] flags_nxt;
	logic [7:0] modem_ctrl_r;
	logic [7:0] int_enable_r;
	logic [7:0] scratch_r;
	logic [7:0] line_ctrl_r;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic [7:0] modem_stat;
	logic [3:0] int_id;
	logic tx_empty_pend_r;
	logic tx_empty_prev_r;
	logic rck_s1_r;
	logic rck_s2_r;
	logic rck_prev_r;
	logic [3:0] rck_cnt_r;
	logic live;
	logic rd_stat;
	logic rd_iid;
	logic [3:0] chg;
	logic loop_mode;

	// register write strobes, one per writable register
	logic wr_mc;
	logic wr_ie;
	logic wr_lc;
	logic wr_sc;

	// interrupt sources before priority: line, rx data, timeout, tx empty, modem
	logic src_line;
	logic src_rx;
	logic src_timeout;
	logic src_tx;
	logic src_modem;

	// either reset input holds the registers; the synchronisers, modem edge register, receive-clock divider, read data and bus enable only see rst_n
	assign live = rst_n && !master_reset_in;
	assign rd_stat = reg_rd && (reg_addr == umsi_pkg::UMSI_OFS_MODEM_STAT);
	assign rd_iid = reg_rd && (reg_addr == umsi_pkg::UMSI_OFS_INT_ID);
	assign loop_mode = modem_ctrl_r[umsi_pkg::UMSI_MC_LOOP];

	assign wr_mc = reg_wr && (reg_addr == umsi_pkg::UMSI_OFS_MODEM_CTRL);
	assign wr_ie = reg_wr && (reg_addr == umsi_pkg::UMSI_OFS_INT_ENABLE);
	assign wr_lc = reg_wr && (reg_addr == umsi_pkg::UMSI_OFS_LINE_CTRL);
	assign wr_sc = reg_wr && (reg_addr == umsi_pkg::UMSI_OFS_SCRATCH);

	// two-stage synchroniser; only stage two feeds edge logic
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sync1_r <= '1;
			sync2_r <= '1;
		end else if (clk_en) begin
			sync1_r <= modem_in;
			sync2_r <= sync1_r;
		end
	end

	// settled level one cycle back, reset to the idle high so no false edge follows reset
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			prev_r <= '1;
		end else if (clk_en) begin
			prev_r <= sync2_r;
		end
	end

	// active-low pins: a flip of level is a change; ring flag on pin low-to-high
	for (genvar gi = 0; gi < 4; gi++) begin : g_chg
		if (gi == 2) begin : g_ring
			assign chg[gi] = sync2_r[gi] & ~prev_r[gi];
		end else begin : g_lvl
			assign chg[gi] = sync2_r[gi] ^ prev_r[gi];
		end
	end

	always_comb begin
		flags_nxt = flags_r;
		if (rd_stat) begin
			flags_nxt = umsi_pkg::UMSI_RST_FLAGS;
		end
		flags_nxt = flags_nxt | chg; // set wins over the read clear
	end

	always_ff @(posedge clock) begin
		if (!live) begin
			flags_r <= umsi_pkg::UMSI_RST_FLAGS;
		end else if (clk_en) begin
			flags_r <= flags_nxt;
		end
	end

	always_comb begin
		modem_stat = 8'h00;
		modem_stat[3:0] = flags_r;
		modem_stat[4] = ~sync2_r.clear_to_send_n;
		modem_stat[5] = ~sync2_r.set_ready_n;
		modem_stat[6] = ~sync2_r.ring_n;
		modem_stat[7] = ~sync2_r.carrier_n;
	end

	// modem control and interrupt enable registers keep only their defined bits; the rest read zero
	always_ff @(posedge clock) begin
		if (!live) begin
			modem_ctrl_r <= umsi_pkg::UMSI_RST_MODEM_CTRL;
		end else if (clk_en && wr_mc) begin
			modem_ctrl_r <= {3'h0, reg_wdata[4:0]};
		end
	end

	always_ff @(posedge clock) begin
		if (!live) begin
			int_enable_r <= umsi_pkg::UMSI_RST_INT_ENABLE;
		end else if (clk_en && wr_ie) begin
			int_enable_r <= {4'h0, reg_wdata[3:0]};
		end
	end

	always_ff @(posedge clock) begin
		if (!live) begin
			line_ctrl_r <= 8'h00;
		end else if (clk_en && wr_lc) begin
			line_ctrl_r <= reg_wdata;
		end
	end

	always_ff @(posedge clock) begin
		if (!live) begin
			scratch_r <= 8'h00;
		end else if (clk_en && wr_sc) begin
			scratch_r <= reg_wdata;
		end
	end

	// transmit-empty interrupt: armed on rising empty, cleared by id read or when the holding register is no longer empty
	always_ff @(posedge clock) begin
		if (!live) begin
			tx_empty_pend_r <= 1'b0;
			tx_empty_prev_r <= 1'b0;
		end else if (clk_en) begin
			tx_empty_prev_r <= tx_holding_empty;
			if (tx_holding_empty && !tx_empty_prev_r) begin
				tx_empty_pend_r <= 1'b1;
			end else if ((rd_iid && int_id == umsi_pkg::UMSI_IID_TXEMPTY) || !tx_holding_empty) begin
				tx_empty_pend_r <= 1'b0;
			end
		end
	end

	// enabled sources; timeout only counts in fifo mode
	assign src_line = int_enable_r[umsi_pkg::UMSI_IE_LINE] && rx_error_evt;
	assign src_rx = int_enable_r[umsi_pkg::UMSI_IE_RXDATA] && rx_data_avail;
	assign src_timeout = int_enable_r[umsi_pkg::UMSI_IE_RXDATA] && fifo_mode && rx_timeout_evt;
	assign src_tx = int_enable_r[umsi_pkg::UMSI_IE_TXEMPTY] && tx_empty_pend_r;
	assign src_modem = int_enable_r[umsi_pkg::UMSI_IE_MODEM] && (flags_r != 4'h0);

	// prioritised interrupt source
	always_comb begin
		int_id = umsi_pkg::UMSI_IID_NONE;
		if (src_line) begin
			int_id = umsi_pkg::UMSI_IID_LINE;
		end else if (src_rx) begin
			int_id = umsi_pkg::UMSI_IID_RXDATA;
		end else if (src_timeout) begin
			int_id = umsi_pkg::UMSI_IID_TIMEOUT;
		end else if (src_tx) begin
			int_id = umsi_pkg::UMSI_IID_TXEMPTY;
		end else if (src_modem) begin
			int_id = umsi_pkg::UMSI_IID_MODEM;
		end
	end

	always_ff @(posedge clock) begin
		if (!live) begin
			interrupt_request_out <= 1'b0;
		end else if (clk_en) begin
			interrupt_request_out <= (int_id != umsi_pkg::UMSI_IID_NONE);
		end
	end

	always_comb begin
		case (reg_addr)
			umsi_pkg::UMSI_OFS_INT_ENABLE: begin
				rdata_nxt = int_enable_r;
			end
			umsi_pkg::UMSI_OFS_INT_ID: begin
				rdata_nxt = {2'h0, 2'h0, int_id};
			end
			umsi_pkg::UMSI_OFS_LINE_CTRL: begin
				rdata_nxt = line_ctrl_r;
			end
			umsi_pkg::UMSI_OFS_MODEM_CTRL: begin
				rdata_nxt = modem_ctrl_r;
			end
			umsi_pkg::UMSI_OFS_MODEM_STAT: begin
				rdata_nxt = modem_stat;
			end
			umsi_pkg::UMSI_OFS_SCRATCH: begin
				rdata_nxt = scratch_r;
			end
			default: begin
				rdata_nxt = 8'h00;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rdata_r <= 8'h00;
			data_bus_oe <= 1'b0;
		end else if (clk_en) begin
			if (reg_rd) begin
				rdata_r <= rdata_nxt;
			end
			data_bus_oe <= reg_rd;
		end
	end

	assign reg_rdata = rdata_r;
	assign data_bus_out = rdata_r;
	assign driver_disable = ~data_bus_oe;

	// modem control outputs, active low, inactive in loop mode
	always_ff @(posedge clock) begin
		if (!live) begin
			terminal_ready_n <= 1'b1;
		end else if (clk_en) begin
			terminal_ready_n <= ~(modem_ctrl_r[umsi_pkg::UMSI_MC_DTR] & ~loop_mode);
		end
	end

	always_ff @(posedge clock) begin
		if (!live) begin
			send_request_n <= 1'b1;
		end else if (clk_en) begin
			send_request_n <= ~(modem_ctrl_r[umsi_pkg::UMSI_MC_RTS] & ~loop_mode);
		end
	end

	always_ff @(posedge clock) begin
		if (!live) begin
			user_output_a <= 1'b1;
		end else if (clk_en) begin
			user_output_a <= ~(modem_ctrl_r[umsi_pkg::UMSI_MC_OUTA] & ~loop_mode);
		end
	end

	always_ff @(posedge clock) begin
		if (!live) begin
			user_output_b <= 1'b1;
		end else if (clk_en) begin
			user_output_b <= ~(modem_ctrl_r[umsi_pkg::UMSI_MC_OUTB] & ~loop_mode);
		end
	end

	// receive clock passes two flip-flops before its edge is taken
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rck_s1_r <= 1'b0;
			rck_s2_r <= 1'b0;
			rck_prev_r <= 1'b0;
		end else if (clk_en) begin
			rck_s1_r <= receive_baud_clock_in;
			rck_s2_r <= rck_s1_r;
			rck_prev_r <= rck_s2_r;
		end
	end

	// one tick per sixteen receive clock rising edges goes to the receiver
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rck_cnt_r <= 4'h0;
			rx_sample_tick <= 1'b0;
		end else if (clk_en) begin
			rx_sample_tick <= 1'b0;
			if (rck_s2_r && !rck_prev_r) begin
				rck_cnt_r <= rck_cnt_r + 4'h1;
				rx_sample_tick <= (rck_cnt_r == 4'(umsi_pkg::UMSI_RX_OVERSAMPLE - 1));
			end
		end
	end
endmodule

// >>> logic/umsi_pkg.sv
// package for the modem signal interface: register offsets, bit positions, reset values
// assumes a single 250 MHz clock domain and a plain register port
package umsi_pkg;
	localparam logic [2:0] UMSI_OFS_INT_ENABLE = 3'h1;
	localparam logic [2:0] UMSI_OFS_INT_ID = 3'h2;
	localparam logic [2:0] UMSI_OFS_LINE_CTRL = 3'h3;
	localparam logic [2:0] UMSI_OFS_MODEM_CTRL = 3'h4;
	localparam logic [2:0] UMSI_OFS_LINE_STAT = 3'h5;
	localparam logic [2:0] UMSI_OFS_MODEM_STAT = 3'h6;
	localparam logic [2:0] UMSI_OFS_SCRATCH = 3'h7;
	localparam int UMSI_MC_DTR = 0;
	localparam int UMSI_MC_RTS = 1;
	localparam int UMSI_MC_OUTA = 2;
	localparam int UMSI_MC_OUTB = 3;
	localparam int UMSI_MC_LOOP = 4;
	localparam int UMSI_IE_RXDATA = 0;
	localparam int UMSI_IE_TXEMPTY = 1;
	localparam int UMSI_IE_LINE = 2;
	localparam int UMSI_IE_MODEM = 3;
	localparam logic [7:0] UMSI_RST_MODEM_CTRL = 8'h00;
	localparam logic [7:0] UMSI_RST_INT_ENABLE = 8'h00;
	localparam logic [3:0] UMSI_RST_FLAGS = 4'h0;
	localparam logic [3:0] UMSI_IID_NONE = 4'h1;
	localparam logic [3:0] UMSI_IID_LINE = 4'h6;
	localparam logic [3:0] UMSI_IID_RXDATA = 4'h4;
	localparam logic [3:0] UMSI_IID_TIMEOUT = 4'hC;
	localparam logic [3:0] UMSI_IID_TXEMPTY = 4'h2;
	localparam logic [3:0] UMSI_IID_MODEM = 4'h0;
	localparam int UMSI_RX_OVERSAMPLE = 16;
	typedef struct packed {
		logic carrier_n;
		logic ring_n;
		logic set_ready_n;
		logic clear_to_send_n;
	} umsi_modem_t;
endpackage

// >>> test/umsi_modem_model.sv
// modem model driving the four status pins of the block
// assumes the bench moves pin_cmd just after a rising clock edge
`timescale 1ns/1ns
module umsi_modem_model (
	input wire logic clock,
	input wire logic [3:0] pin_cmd,
	output umsi_pkg::umsi_modem_t modem_in
);
	initial modem_in = 4'hF;
	// pins move 1 ns after the edge, unrelated to the block's sampling
	always @(posedge clock) modem_in <= #1 pin_cmd;
endmodule

// >>> test/umsi_sva.sv
// port checker for umsi_top
// assumes clk_en is held high while traffic runs
`timescale 1ns/1ns
module umsi_sva (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic master_reset_in,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic data_bus_oe,
	input wire logic driver_disable,
	input wire logic terminal_ready_n,
	input wire logic send_request_n,
	input wire logic user_output_a,
	input wire logic user_output_b,
	input wire logic interrupt_request_out,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire umsi_pkg::umsi_modem_t modem_in
);
	logic rd_stat;
	assign rd_stat = clk_en && reg_rd && reg_addr == umsi_pkg::UMSI_OFS_MODEM_STAT;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence mcw;
		clk_en && reg_wr && reg_addr == umsi_pkg::UMSI_OFS_MODEM_CTRL && !master_reset_in ##1 !master_reset_in;
	endsequence
	AST_DTR: assert property (mcw |=> terminal_ready_n == !($past(reg_wdata[0], 2) && !$past(reg_wdata[4], 2)))
		else $error("terminal ready wrong after control write");
	AST_RTS: assert property (mcw |=> send_request_n == !($past(reg_wdata[1], 2) && !$past(reg_wdata[4], 2)))
		else $error("send request wrong after control write");
	AST_USR: assert property (mcw |=> user_output_a == !($past(reg_wdata[2], 2) && !$past(reg_wdata[4], 2))
		&& user_output_b == !($past(reg_wdata[3], 2) && !$past(reg_wdata[4], 2))) else $error("user output wrong");
	AST_MR: assert property (master_reset_in ##1 master_reset_in |=> terminal_ready_n && send_request_n
		&& user_output_a && user_output_b && !interrupt_request_out) else $error("outputs not reset");
	AST_DRIVER_DISABLE_RD: assert property (clk_en && reg_rd && !master_reset_in |=> data_bus_oe && !driver_disable)
		else $error("bus not driven after read");
	AST_DRIVER_DISABLE_IDLE: assert property (clk_en && !reg_rd |=> driver_disable && !data_bus_oe)
		else $error("bus driven without read");
	AST_MSR: assert property ($stable(modem_in)[*6] ##0 rd_stat |=> reg_rdata[7:4] == ~$past(modem_in))
		else $error("status levels wrong");
	AST_FLAGCLR: assert property ($stable(modem_in)[*6] ##0 rd_stat ##1 $stable(modem_in)[*2] ##0 rd_stat
		|=> reg_rdata[3:0] == 4'h0) else $error("change flags not cleared by read");
endmodule
bind umsi_top umsi_sva umsi_sva_i (.*);

// >>> test/umsi_top_tb.sv
// self-checking bench for umsi_top
// assumes the modem model drives the status pins
`timescale 1ns/1ns
module umsi_top_tb;
	localparam logic [2:0] MC = umsi_pkg::UMSI_OFS_MODEM_CTRL, MS = umsi_pkg::UMSI_OFS_MODEM_STAT;
	localparam logic [2:0] IE = umsi_pkg::UMSI_OFS_INT_ENABLE, II = umsi_pkg::UMSI_OFS_INT_ID;
	logic clock = 0, rst_n = 0, clk_en = 1, master_reset_in = 0, reg_wr = 0, reg_rd = 0;
	logic receive_baud_clock_in = 0, rx_error_evt = 0, rx_data_avail = 0, rx_timeout_evt = 0, fifo_mode = 0;
	logic tx_holding_empty = 0, data_bus_oe, driver_disable, terminal_ready_n, send_request_n;
	logic user_output_a, user_output_b, interrupt_request_out, rx_sample_tick;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00, data_bus_in = 8'h00, reg_rdata, data_bus_out, rd, e;
	logic [3:0] pin_cmd = 4'hF;
	umsi_pkg::umsi_modem_t modem_in;
	int n_fail = 0, n_tests = 0, cyc = 0, ticks = 0;
	umsi_top umsi_top_i (.*);
	umsi_modem_model umsi_modem_model_i (.clock(clock), .pin_cmd(pin_cmd), .modem_in(modem_in));
	always #2 clock = ~clock;
	always #20 receive_baud_clock_in = ~receive_baud_clock_in;
	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rdr(input logic [2:0] a);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		rd = reg_rdata;
		chk({7'h00, driver_disable}, 8'h00);
	endtask
	function automatic logic [7:0] outs();
		return {4'h0, user_output_b, user_output_a, send_request_n, terminal_ready_n};
	endfunction
	initial begin
		wt(16);
		rst_n <= 1'b1;
		wt(8);
		chk(outs(), 8'h0F);
		chk({7'h00, driver_disable}, 8'h01);
		rdr(MS);
		for (int i = 0; i < 5; i++) begin
			e = (i < 4) ? (8'h01 << i) : 8'h1F;
			wr(MC, e);
			wt(3);
			chk(outs(), (i < 4) ? (~e & 8'h0F) : 8'h0F);
		end
		$display("control outputs test done");
		wr(IE, 8'h08);
		for (int i = 0; i < 8; i++) begin
			@(posedge clock);
			pin_cmd[i % 4] <= (i >= 4);
			wt(8);
			chk({7'h00, interrupt_request_out}, {7'h00, i != 2});
			rdr(MS);
			e = {~pin_cmd, 4'h0};
			e[i % 4] = (i != 2);
			chk(rd, e);
			chk(data_bus_out, e);
			wt(2);
			chk({7'h00, interrupt_request_out}, 8'h00);
			rdr(MS);
			chk(rd, {~pin_cmd, 4'h0});
		end
		rdr(MS);
		rdr(MS);
		chk(rd, {~pin_cmd, 4'h0});
		$display("modem status test done");
		wr(IE, 8'h02);
		@(posedge clock);
		tx_holding_empty <= 1'b1;
		wt(4);
		chk({7'h00, interrupt_request_out}, 8'h01);
		rdr(II);
		chk(rd, {4'h0, umsi_pkg::UMSI_IID_TXEMPTY});
		wt(2);
		chk({7'h00, interrupt_request_out}, 8'h00);
		wr(MC, 8'h0F);
		wr(IE, 8'h01);
		@(posedge clock);
		rx_data_avail <= 1'b1;
		wt(4);
		chk({7'h00, interrupt_request_out}, 8'h01);
		master_reset_in <= 1'b1;
		wt(4);
		chk(outs(), 8'h0F);
		chk({7'h00, interrupt_request_out}, 8'h00);
		master_reset_in <= 1'b0;
		rdr(MC);
		chk(rd, 8'h00);
		chk(data_bus_out, 8'h00);
		$display("interrupt and reset test done");
		@(posedge clock);
		rx_data_avail <= 1'b0;
		fifo_mode <= 1'b1;
		rx_timeout_evt <= 1'b1;
		wr(IE, 8'h05);
		rdr(II);
		chk(rd, {4'h0, umsi_pkg::UMSI_IID_TIMEOUT});
		@(posedge clock);
		rx_error_evt <= 1'b1;
		rdr(II);
		chk(rd, {4'h0, umsi_pkg::UMSI_IID_LINE});
		wr(umsi_pkg::UMSI_OFS_SCRATCH, 8'hA5);
		rdr(umsi_pkg::UMSI_OFS_SCRATCH);
		chk(rd, 8'hA5);
		chk(data_bus_out, 8'hA5);
		$display("priority and scratch test done");
		@(posedge clock);
		repeat (320) @(posedge clock) if (rx_sample_tick === 1'b1) ticks++;
		chk(ticks[7:0], 8'h02);
		$display("receive clock test done");
		report_and_stop();
	end
endmodule
